// file: logic/ipm_positioner.sv
// Contract
// - degree step moves relative, hundredths of degree
// - degree argument within plus/minus 3 600 000
// - accept only with servo energised
// - accept only with no motion running
// - accept only without alarm or warning stop
// - accept only while halt_input inactive
// - degree position report tracks present position
// - settle window 0..2621439, resets to 400
// - settled only after window held settle time
// - pin level monitor shows raw pin states
// - recognition monitor after polarity, debounce, hold
// - input function monitor after polarity, debounce
// - output function monitor before hold and logic
// - user step divides revolution by user_divisions
// - user argument within user_divisions times 100
// - user position report in division units
// - pulse argument within plus/minus 262 144 000
// - pulse position report in feedback pulses
// - settle timer 0 to 10000.0 ms
`include "ipm_consts.svh"

module ipm_positioner
    import ipm_pkg::*;
#(
    parameter int N_IN = 8,
    parameter int N_OUT = 8,
    parameter int TICK_CYC = `IPM_TICK_CYC
)
(
    input wire logic i_clk_sys, // 100 MHz clock
    input wire logic i_rst, // sync reset, high
    input wire logic [7:0] i_addr, // register byte address
    input wire logic [31:0] i_wr_data, // write data
    input wire logic i_wr, // write strobe
    input wire logic i_rd, // read strobe
    output logic [31:0] o_rd_data, // read data, next cycle
    input wire logic i_servo_on, // servo energised
    input wire logic i_alarm_stop, // held by alarm/warning
    input wire logic i_jog_active, // jog in progress
    input wire logic i_home_active, // home return running
    input wire logic i_move_done, // servo finished a move
    input wire logic [31:0] i_fb_pos, // position, pulses
    input wire logic [31:0] i_pos_err, // position error
    input wire logic [N_IN-1:0] i_pin_in, // connector inputs
    input wire logic [N_OUT-1:0] i_out_func, // output functions
    output logic o_move_start, // one-cycle move pulse
    output logic [31:0] o_move_incr, // move size, pulses
    output logic o_cmd_reject, // one-cycle reject pulse
    output logic o_settled, // settled_output
    output logic [N_OUT-1:0] o_pin_out // connector outputs
);

    // ======================================================
    // elaboration checks
    // two low output bits are replaced by busy and settled
    if (N_IN < 1 || N_IN > 16 || N_OUT < 3 || N_OUT > 16)
    begin : g_bad_width
        $error("ipm_positioner: pin counts out of range");
    end
    if (TICK_CYC < 1 || TICK_CYC > 65535)
    begin : g_bad_tick
        $error("ipm_positioner: tick count out of range");
    end

    // ======================================================
    // declarations
    ipm_state_type state_q;
    ipm_cmd_type cmd_kind;
    logic [21:0] win_q;
    logic [16:0] tmr_q;
    logic [23:0] qr_q;
    logic [N_IN-1:0] pol_q;
    logic [15:0] dbt_q;
    logic [15:0] hold_q;
    logic [N_OUT-1:0] logic_q;
    logic busy_q;
    logic rej_cond_q;
    logic rej_range_q;
    logic settled_q;
    logic neg_q;
    logic [31:0] incr_q;
    logic [31:0] pos_q;
    logic [31:0] deg_pos_q;
    logic [31:0] user_pos_q;
    logic [15:0] tick_cnt_q;
    logic tick_q;
    logic [16:0] stab_cnt_q;
    logic [N_IN-1:0] in_rec;
    logic [N_OUT-1:0] out_func;
    logic [N_OUT-1:0] out_stab;
    logic [N_OUT-1:0] out_func_q;
    logic [55:0] dvd_q;
    logic [32:0] rem_q;
    logic [31:0] dvs_q;
    logic [5:0] div_cnt_q;
    logic div_run_q;
    logic div_done_q;
    logic [32:0] rem_n;
    logic [31:0] quo_s;
    logic cmd_wr;
    logic cond_ok;
    logic range_ok;
    logic cmd_ok;
    logic load_cmd;
    logic load_ref;
    logic [32:0] arg_ext;
    logic [32:0] mag_w;
    logic [32:0] pos_ext;
    logic [32:0] pos_mag;
    logic [32:0] err_ext;
    logic [32:0] err_mag;
    logic in_win;
    logic halt_in;
    logic signed [47:0] deg_prod;
    logic [31:0] rd_d;

    // ======================================================
    // command decode and acceptance
    always_comb
    begin
        case (i_addr)
            `IPM_REG_DEG_STEP: cmd_kind = IPM_CMD_DEG;
            `IPM_REG_USER_STEP: cmd_kind = IPM_CMD_USER;
            `IPM_REG_PULSE_STEP: cmd_kind = IPM_CMD_PULSE;
            default: cmd_kind = IPM_CMD_NONE;
        endcase
    end

    assign cmd_wr = i_wr && (cmd_kind != IPM_CMD_NONE);
    assign arg_ext = {i_wr_data[31], i_wr_data};
    assign mag_w = i_wr_data[31] ? 33'(~arg_ext + 33'd1) : arg_ext;
    assign halt_in = in_rec[0];

    assign cond_ok = i_servo_on
        && !i_alarm_stop
        && !halt_in
        && !busy_q && !i_jog_active && !i_home_active
        && (state_q == IPM_ST_IDLE || state_q == IPM_ST_REFRESH);

    always_comb
    begin
        case (cmd_kind)
            IPM_CMD_DEG: range_ok = mag_w <= `IPM_DEG_MAX;
            IPM_CMD_USER: range_ok = (qr_q != 24'd0)
                && ({31'd0, mag_w} <= 64'(qr_q) * `IPM_USER_MUL);
            IPM_CMD_PULSE: range_ok = mag_w <= `IPM_PULSE_MAX;
            default: range_ok = 1'b0;
        endcase
    end

    assign cmd_ok = cmd_wr && cond_ok && range_ok;
    assign load_cmd = cmd_ok && (cmd_kind != IPM_CMD_PULSE);
    assign load_ref = (state_q == IPM_ST_IDLE) && !cmd_wr
        && !div_run_q && (qr_q != 24'd0);

    // ======================================================
    // shared restoring divider for scale conversion
    assign pos_ext = {pos_q[31], pos_q};
    assign pos_mag = pos_q[31] ? 33'(~pos_ext + 33'd1) : pos_ext;
    assign rem_n = {rem_q[31:0], dvd_q[55]};
    assign quo_s = neg_q ? 32'(~dvd_q[31:0] + 32'd1) : dvd_q[31:0];

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            dvd_q <= 56'h0;
            rem_q <= 33'h0;
            dvs_q <= 32'h1;
            div_cnt_q <= 6'h0;
            div_run_q <= 1'b0;
            div_done_q <= 1'b0;
        end
        else if (load_cmd)
        begin
            rem_q <= 33'h0;
            div_cnt_q <= 6'd55;
            div_run_q <= 1'b1;
            div_done_q <= 1'b0;
            if (cmd_kind == IPM_CMD_DEG)
            begin
                dvd_q <= {23'd0, mag_w} << `IPM_DEG_SHIFT;
                dvs_q <= `IPM_DEG_DEN;
            end
            else
            begin
                dvd_q <= {23'd0, mag_w} * 56'(`IPM_PULSES_PER_REV);
                dvs_q <= 32'(qr_q);
            end
        end
        else if (load_ref)
        begin
            rem_q <= 33'h0;
            div_cnt_q <= 6'd55;
            div_run_q <= 1'b1;
            div_done_q <= 1'b0;
            dvd_q <= {23'd0, pos_mag} * {32'd0, qr_q};
            dvs_q <= `IPM_PULSES_PER_REV;
        end
        else if (div_run_q)
        begin
            if (rem_n >= {1'b0, dvs_q})
            begin
                rem_q <= 33'(rem_n - {1'b0, dvs_q});
                dvd_q <= {dvd_q[54:0], 1'b1};
            end
            else
            begin
                rem_q <= rem_n;
                dvd_q <= {dvd_q[54:0], 1'b0};
            end
            div_cnt_q <= 6'(div_cnt_q - 6'd1);
            div_run_q <= div_cnt_q != 6'd0;
            div_done_q <= div_cnt_q == 6'd0;
        end
        else
        begin
            div_done_q <= 1'b0;
        end
    end

    // ======================================================
    // positioning sequencer
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state_q <= IPM_ST_IDLE;
            incr_q <= 32'h0;
            neg_q <= 1'b0;
            user_pos_q <= 32'h0;
        end
        else
        begin
            case (state_q)
                IPM_ST_IDLE, IPM_ST_REFRESH:
                begin
                    if (cmd_ok && cmd_kind == IPM_CMD_PULSE)
                    begin
                        incr_q <= i_wr_data;
                        state_q <= IPM_ST_ISSUE;
                    end
                    else if (load_cmd)
                    begin
                        neg_q <= i_wr_data[31];
                        state_q <= IPM_ST_DIV;
                    end
                    else if (load_ref)
                    begin
                        neg_q <= pos_q[31];
                        state_q <= IPM_ST_REFRESH;
                    end
                    else if (state_q == IPM_ST_REFRESH && div_done_q)
                    begin
                        user_pos_q <= quo_s;
                        state_q <= IPM_ST_IDLE;
                    end
                    else if (qr_q == 24'd0)
                    begin
                        user_pos_q <= 32'h0;
                        state_q <= IPM_ST_IDLE;
                    end
                end
                IPM_ST_DIV:
                begin
                    if (div_done_q)
                    begin
                        incr_q <= quo_s;
                        state_q <= IPM_ST_ISSUE;
                    end
                end
                IPM_ST_ISSUE:
                begin
                    state_q <= IPM_ST_IDLE;
                end
                default:
                begin
                    state_q <= IPM_ST_IDLE;
                end
            endcase
        end
    end

    // ======================================================
    // move issue, busy and reject status
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_move_start <= 1'b0;
            o_move_incr <= 32'h0;
            busy_q <= 1'b0;
        end
        else
        begin
            o_move_start <= state_q == IPM_ST_ISSUE;
            if (state_q == IPM_ST_ISSUE)
            begin
                o_move_incr <= incr_q;
            end
            // start wins over a coincident completion
            busy_q <= (state_q == IPM_ST_ISSUE)
                || (busy_q && !i_move_done);
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_cmd_reject <= 1'b0;
            rej_cond_q <= 1'b0;
            rej_range_q <= 1'b0;
        end
        else
        begin
            o_cmd_reject <= cmd_wr && !cmd_ok;
            if (cmd_wr)
            begin
                rej_cond_q <= !cond_ok;
                rej_range_q <= !range_ok;
            end
        end
    end

    // ======================================================
    // position reports
    assign deg_prod = 48'($signed(pos_q)) * `IPM_DEG_REP_MUL;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            pos_q <= 32'h0;
            deg_pos_q <= 32'h0;
        end
        else
        begin
            pos_q <= i_fb_pos;
            deg_pos_q <= deg_prod[`IPM_DEG_SHIFT +: 32];
        end
    end

    // ======================================================
    // 0.1 ms tick and in-position detection
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || tick_cnt_q == 16'(TICK_CYC - 1))
        begin
            tick_cnt_q <= 16'h0;
            tick_q <= !i_rst;
        end
        else
        begin
            tick_cnt_q <= 16'(tick_cnt_q + 16'd1);
            tick_q <= 1'b0;
        end
    end

    assign err_ext = {i_pos_err[31], i_pos_err};
    assign err_mag = i_pos_err[31] ? 33'(~err_ext + 33'd1) : err_ext;
    assign in_win = err_mag <= {11'd0, win_q};

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            stab_cnt_q <= 17'h0;
            settled_q <= 1'b0;
        end
        else
        begin
            if (!in_win)
            begin
                stab_cnt_q <= 17'h0;
            end
            else if (tick_q && stab_cnt_q < tmr_q)
            begin
                stab_cnt_q <= 17'(stab_cnt_q + 17'd1);
            end
            settled_q <= in_win && (stab_cnt_q >= tmr_q);
        end
    end

    assign o_settled = settled_q;

    // ======================================================
    // input conditioning: polarity, then debounce
    for (genvar gi = 0; gi < N_IN; gi++)
    begin : g_in
        logic stab_q;
        logic [15:0] cnt_q;
        logic raw;
        assign raw = i_pin_in[gi] ^ pol_q[gi];
        always_ff @(posedge i_clk_sys)
        begin
            if (i_rst || raw == stab_q)
            begin
                stab_q <= i_rst ? 1'b0 : stab_q;
                cnt_q <= 16'h0;
            end
            else if (cnt_q >= dbt_q)
            begin
                stab_q <= raw;
                cnt_q <= 16'h0;
            end
            else if (tick_q)
            begin
                cnt_q <= 16'(cnt_q + 16'd1);
            end
        end
        assign in_rec[gi] = stab_q;
    end

    // ======================================================
    // output conditioning: hold timer, then logic
    assign out_func = {i_out_func[N_OUT-1:2], busy_q, settled_q};

    for (genvar go = 0; go < N_OUT; go++)
    begin : g_out
        logic stab_q;
        logic [15:0] cnt_q;
        always_ff @(posedge i_clk_sys)
        begin
            if (i_rst || out_func[go] == stab_q)
            begin
                stab_q <= i_rst ? 1'b0 : stab_q;
                cnt_q <= 16'h0;
            end
            else if (cnt_q >= hold_q)
            begin
                stab_q <= out_func[go];
                cnt_q <= 16'h0;
            end
            else if (tick_q)
            begin
                cnt_q <= 16'(cnt_q + 16'd1);
            end
        end
        assign out_stab[go] = stab_q;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            o_pin_out <= '0;
            out_func_q <= '0;
        end
        else
        begin
            o_pin_out <= out_stab ^ logic_q;
            out_func_q <= out_func;
        end
    end

    // ======================================================
    // settings registers
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            win_q <= `IPM_WIN_RST;
            tmr_q <= `IPM_TMR_RST;
            qr_q <= `IPM_QR_RST;
            pol_q <= '0;
            dbt_q <= 16'h0;
            hold_q <= 16'h0;
            logic_q <= '0;
        end
        else if (i_wr)
        begin
            case (i_addr)
                `IPM_REG_SETTLE_WIN:
                    if (i_wr_data <= 32'(`IPM_WIN_MAX))
                        win_q <= i_wr_data[21:0];
                `IPM_REG_SETTLE_TMR:
                    if (i_wr_data <= 32'(`IPM_TMR_MAX))
                        tmr_q <= i_wr_data[16:0];
                `IPM_REG_USER_DIV: qr_q <= i_wr_data[23:0];
                `IPM_REG_IN_POL: pol_q <= i_wr_data[N_IN-1:0];
                `IPM_REG_DEBOUNCE: dbt_q <= i_wr_data[15:0];
                `IPM_REG_OUT_HOLD: hold_q <= i_wr_data[15:0];
                `IPM_REG_OUT_LOGIC: logic_q <= i_wr_data[N_OUT-1:0];
                default: ;
            endcase
        end
    end

    // ======================================================
    // read port
    always_comb
    begin
        rd_d = 32'h0;
        case (i_addr)
            `IPM_REG_STATUS:
            begin
                rd_d[`IPM_ST_BUSY] = busy_q;
                rd_d[`IPM_ST_SETTLED] = settled_q;
                rd_d[`IPM_ST_REJ_COND] = rej_cond_q;
                rd_d[`IPM_ST_REJ_RANGE] = rej_range_q;
                rd_d[`IPM_ST_CONV] = state_q == IPM_ST_DIV;
            end
            `IPM_REG_SETTLE_WIN: rd_d = 32'(win_q);
            `IPM_REG_SETTLE_TMR: rd_d = 32'(tmr_q);
            `IPM_REG_USER_DIV: rd_d = 32'(qr_q);
            `IPM_REG_IN_POL: rd_d = 32'(pol_q);
            `IPM_REG_DEBOUNCE: rd_d = 32'(dbt_q);
            `IPM_REG_OUT_HOLD: rd_d = 32'(hold_q);
            `IPM_REG_OUT_LOGIC: rd_d = 32'(logic_q);
            `IPM_REG_DEG_POS: rd_d = deg_pos_q;
            `IPM_REG_USER_POS: rd_d = user_pos_q;
            `IPM_REG_PULSE_POS: rd_d = pos_q;
            `IPM_REG_PIN_LEVEL:
                rd_d = {16'(o_pin_out), 16'(i_pin_in)};
            `IPM_REG_RECOG:
                rd_d = {16'(out_stab), 16'(in_rec)};
            `IPM_REG_IN_FUNC: rd_d = 32'(in_rec);
            `IPM_REG_OUT_FUNC: rd_d = 32'(out_func_q);
            default: rd_d = 32'h0;
        endcase
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst || !i_rd)
        begin
            o_rd_data <= 32'h0;
        end
        else
        begin
            o_rd_data <= rd_d;
        end
    end

    // ======================================================
    // checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_servo_off_reject: assert property (
        cmd_wr && !i_servo_on |=> o_cmd_reject)
        else $error("command accepted with servo off");
    a_busy_reject: assert property (
        cmd_wr && busy_q |=> o_cmd_reject ##1 !o_move_start)
        else $error("command accepted during motion");
    a_alarm_reject: assert property (
        cmd_wr && i_alarm_stop |=> o_cmd_reject)
        else $error("command accepted during alarm stop");
    a_halt_reject: assert property (
        cmd_wr && halt_in |=> o_cmd_reject)
        else $error("command accepted while halted");
    a_deg_range: assert property (
        cmd_wr && cmd_kind == IPM_CMD_DEG && mag_w > `IPM_DEG_MAX
        |=> o_cmd_reject)
        else $error("degree argument out of range accepted");
    a_pulse_issue: assert property (
        cmd_ok && cmd_kind == IPM_CMD_PULSE
        |-> ##2 o_move_start && o_move_incr == $past(i_wr_data, 2))
        else $error("pulse step not issued as written");
    a_conv_issue: assert property (
        load_cmd |-> ##[58:62] o_move_start)
        else $error("converted step not issued in time");
    a_reject_still: assert property (
        cmd_wr && !cmd_ok && state_q != IPM_ST_DIV
        && state_q != IPM_ST_ISSUE |=> !o_move_start [*2])
        else $error("rejected command started motion");
    a_settle_window: assert property (
        o_settled |-> $past(in_win) && $past(stab_cnt_q >= tmr_q))
        else $error("settled without window and time");
    a_window_reset: assert property (
        $past(i_rst) |-> win_q == `IPM_WIN_RST)
        else $error("settle window reset value wrong");
    a_out_func_raw: assert property (
        ##1 out_func_q == $past(out_func))
        else $error("output function monitor not raw");

    c_pulse_move: cover property (
        cmd_ok && cmd_kind == IPM_CMD_PULSE ##2 o_move_start);
    c_deg_move: cover property (load_cmd ##[58:62] o_move_start);
    c_settled: cover property ($rose(o_settled));
    c_reject: cover property (o_cmd_reject);

endmodule // ipm_positioner

// file: shared/ipm_consts.svh
`ifndef IPM_CONSTS_SVH
`define IPM_CONSTS_SVH

// ==========================================================
// register byte offsets
`define IPM_REG_DEG_STEP   8'h00
`define IPM_REG_USER_STEP  8'h04
`define IPM_REG_PULSE_STEP 8'h08
`define IPM_REG_STATUS     8'h0c
`define IPM_REG_SETTLE_WIN 8'h10
`define IPM_REG_SETTLE_TMR 8'h14
`define IPM_REG_USER_DIV   8'h18
`define IPM_REG_IN_POL     8'h1c
`define IPM_REG_DEBOUNCE   8'h20
`define IPM_REG_OUT_HOLD   8'h24
`define IPM_REG_OUT_LOGIC  8'h28
`define IPM_REG_DEG_POS    8'h2c
`define IPM_REG_USER_POS   8'h30
`define IPM_REG_PULSE_POS  8'h34
`define IPM_REG_PIN_LEVEL  8'h38
`define IPM_REG_RECOG      8'h3c
`define IPM_REG_IN_FUNC    8'h40
`define IPM_REG_OUT_FUNC   8'h44

// ==========================================================
// status bit positions
`define IPM_ST_BUSY       0
`define IPM_ST_SETTLED    1
`define IPM_ST_REJ_COND   2
`define IPM_ST_REJ_RANGE  3
`define IPM_ST_CONV       4

// ==========================================================
// ranges, scaling and reset values
`define IPM_DEG_MAX        33'd3600000
`define IPM_PULSE_MAX      33'd262144000
`define IPM_USER_MUL       64'd100
`define IPM_PULSES_PER_REV 32'd2621440
`define IPM_DEG_DEN        32'd225
`define IPM_DEG_SHIFT      14
`define IPM_DEG_REP_MUL    48'sd225
`define IPM_WIN_MAX        22'd2621439
`define IPM_WIN_RST        22'd400
`define IPM_TMR_MAX        17'd100000
`define IPM_TMR_RST        17'd0
`define IPM_QR_RST         24'd360

// ==========================================================
// timing: one tick is 0.1 ms
`define IPM_CLK_NS         10
`define IPM_TICK_NS        100000
`define IPM_TICK_CYC       (`IPM_TICK_NS / `IPM_CLK_NS)

`endif

// file: shared/ipm_pkg.sv
package ipm_pkg;

    // ======================================================
    // positioning sequencer states, gray from IDLE through DIV to ISSUE
    typedef enum logic [1:0]
    {
        IPM_ST_IDLE    = 2'b00,
        IPM_ST_DIV     = 2'b01,
        IPM_ST_ISSUE   = 2'b11,
        IPM_ST_REFRESH = 2'b10
    } ipm_state_type;

    typedef enum logic [1:0]
    {
        IPM_CMD_DEG   = 2'b00,
        IPM_CMD_USER  = 2'b01,
        IPM_CMD_PULSE = 2'b10,
        IPM_CMD_NONE  = 2'b11
    } ipm_cmd_type;

endpackage

// file: testbench/ipm_positioner_test.sv
module ipm_positioner_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ======================================================
    // stimulus and instances
    logic i_clk_sys = 0, i_rst = 1, i_wr = 0, i_rd = 0, i_servo_on = 1;
    logic i_alarm_stop = 0, i_jog_active = 0, i_home_active = 0;
    logic [7:0] i_addr = 8'h00, i_pin_in = 8'h00, i_out_func = 8'h00;
    logic [31:0] i_wr_data = 32'h0, i_pos_err = 32'h0, d;
    logic [31:0] i_fb_pos, o_rd_data, o_move_incr;
    logic i_move_done, o_move_start, o_cmd_reject, o_settled;
    logic [7:0] o_pin_out;
    int n_errors = 0, n_tests = 0;
    always #5 i_clk_sys = ~i_clk_sys;
    ipm_positioner #(.TICK_CYC(10)) ipm_positioner_inst (.i_clk_sys,
        .i_rst, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data, .i_servo_on,
        .i_alarm_stop, .i_jog_active, .i_home_active, .i_move_done,
        .i_fb_pos, .i_pos_err, .i_pin_in, .i_out_func, .o_move_start,
        .o_move_incr, .o_cmd_reject, .o_settled, .o_pin_out);
    ipm_servo_model ipm_servo_model_inst (.i_clk_sys, .i_rst,
        .i_move_start(o_move_start), .i_move_incr(o_move_incr),
        .o_move_done(i_move_done), .o_fb_pos(i_fb_pos));
    // ======================================================
    // bus and compare helpers
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_wr_data <= v;
        i_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk_sys);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 d = o_rd_data;
    endtask
    task automatic refuse(input logic [7:0] a, input logic [31:0] v);
        wr(a, v);
        chk("reject", 32'h1, {31'h0, o_cmd_reject});
        @(posedge i_clk_sys);
        #1 chk("no_start", 32'h0, {31'h0, o_move_start});
    endtask
    task automatic await_move(input logic [31:0] incr);
        for (int k = 0; k < 80 && o_move_start !== 1'b1; k++)
            @(posedge i_clk_sys) #1;
        chk("start", 32'h1, {31'h0, o_move_start});
        chk("incr", incr, o_move_incr);
        repeat (25) @(posedge i_clk_sys);
    endtask
    // ======================================================
    // scenarios
    task automatic t_settle;
        rd(8'h10);
        chk("win_rst", 32'h190, d);
        wr(8'h10, 32'h280000);
        rd(8'h10);
        chk("win_max", 32'h190, d);
        repeat (3) @(posedge i_clk_sys) #1;
        chk("settled", 32'h1, {31'h0, o_settled});
        i_pos_err <= 32'h191;
        repeat (3) @(posedge i_clk_sys) #1;
        chk("unsettled", 32'h0, {31'h0, o_settled});
        i_pos_err <= 32'hfffffe70;
        repeat (3) @(posedge i_clk_sys) #1;
        chk("neg_in_win", 32'h1, {31'h0, o_settled});
        wr(8'h14, 32'h3);
        i_pos_err <= 32'h191;
        repeat (3) @(posedge i_clk_sys);
        i_pos_err <= 32'h0;
        repeat (15) @(posedge i_clk_sys) #1;
        chk("early", 32'h0, {31'h0, o_settled});
        repeat (35) @(posedge i_clk_sys) #1;
        chk("timed", 32'h1, {31'h0, o_settled});
    endtask
    task automatic t_mon;
        i_pin_in <= 8'h5a;
        repeat (3) @(posedge i_clk_sys);
        rd(8'h38);
        chk("pin_level", 32'h0001005a, d);
        chk("pin_out", 32'h1, {24'h0, o_pin_out});
        rd(8'h3c);
        chk("recog", 32'h0001005a, d);
        rd(8'h40);
        chk("in_func", 32'h5a, d);
        wr(8'h28, 32'h3);
        rd(8'h44);
        chk("out_func", 32'h1, d);
        chk("pin_inv", 32'h2, {24'h0, o_pin_out});
        i_pin_in <= 8'h00;
    endtask
    task automatic t_pulse;
        wr(8'h08, 32'hfffffc18);
        @(posedge i_clk_sys) #1;
        chk("start", 32'h1, {31'h0, o_move_start});
        chk("incr", 32'hfffffc18, o_move_incr);
        refuse(8'h08, 32'h10);
        repeat (25) @(posedge i_clk_sys);
        rd(8'h34);
        chk("pulse_pos", 32'hfffffc18, d);
    endtask
    task automatic t_scaled;
        wr(8'h00, 32'h8ca0);
        await_move(32'h00280000);
        rd(8'h2c);
        chk("deg_pos", 32'h8c92, d);
        wr(8'h04, 32'hffffffff);
        await_move(32'hffffe38f);
        // background refresh needs up to two divide rounds
        repeat (130) @(posedge i_clk_sys);
        rd(8'h30);
        chk("user_pos", 32'h166, d);
    endtask
    task automatic t_range;
        refuse(8'h00, 32'h0036ee81);
        refuse(8'h08, 32'h0fa00001);
        refuse(8'h04, 32'h00008ca1);
        rd(8'h0c);
        chk("rej_flags", 32'h8, d & 32'hc);
    endtask
    task automatic t_cond;
        logic [4:0] c;
        for (int k = 0; k < 5; k++)
        begin
            c = 5'h1 << k;
            i_servo_on <= !c[0];
            i_alarm_stop <= c[1];
            i_jog_active <= c[2];
            i_home_active <= c[3];
            i_pin_in <= {7'h0, c[4]};
            repeat (3) @(posedge i_clk_sys);
            refuse(8'h08, 32'h64);
        end
    endtask
    // ======================================================
    // sequence, watchdog and verdict
    task automatic report_and_stop;
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_settle;
        t_mon;
        t_pulse;
        t_scaled;
        t_range;
        t_cond;
        report_and_stop;
    end
    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        n_errors++;
        report_and_stop;
    end
endmodule // ipm_positioner_test

// file: testbench/ipm_servo_model.sv
// ==========================================================
// servo loop: finishes each issued move after DELAY cycles
module ipm_servo_model #(
    parameter int DELAY = 20
)
(
    input wire logic i_clk_sys, // clock
    input wire logic i_rst, // sync reset, high
    input wire logic i_move_start, // move request pulse
    input wire logic [31:0] i_move_incr, // move size, pulses
    output logic o_move_done, // move finished pulse
    output logic [31:0] o_fb_pos // present position, pulses
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    always_ff @(posedge i_clk_sys)
    begin
        o_move_done <= 1'b0;
        if (i_rst)
        begin
            cnt_q <= 0;
            o_fb_pos <= 32'h0;
        end
        else if (i_move_start)
            cnt_q <= DELAY;
        else if (cnt_q == 1)
        begin
            o_move_done <= 1'b1;
            o_fb_pos <= o_fb_pos + i_move_incr;
            cnt_q <= 0;
        end
        else if (cnt_q > 1)
            cnt_q <= cnt_q - 1;
    end
endmodule // ipm_servo_model
